//--- nia_cfg.svh
// Purpose: named constants of the nested acceptance block
// Assumes: included by bare name wherever a constant is needed
// Notes:   offsets are APB byte addresses, one 32-bit word each
`ifndef NIA_CFG_SVH
`define NIA_CFG_SVH

// ============================================================
// Register offsets
`define NIA_OFF_PSW      8'h00
`define NIA_OFF_PEND     8'h04
`define NIA_OFF_MASK     8'h08
`define NIA_OFF_LVL      8'h0C
`define NIA_OFF_STS      8'h10
`define NIA_OFF_CLR      8'h14
`define NIA_OFF_EN       8'h18

// ============================================================
// Status word layout and reset values
`define NIA_PSW_FLAG_BIT 7
`define NIA_PSW_CODE_LSB 1
`define NIA_FLAG_RST     1'h0
`define NIA_CODE_IDLE    2'h3
`define NIA_LVL_TOP      2'h0
`define NIA_LVL_STEP     2'h1

// ============================================================
// Event bits of the status, clear and enable registers
`define NIA_EV_ACC       0
`define NIA_EV_NEST      1
`define NIA_EV_OVF       2
`define NIA_EV_W         3

// ============================================================
// Bus widths
`define NIA_DW           32
`define NIA_AW           8

`endif

//--- nia_pkg.sv
// Purpose: types and shared decoding of the nested acceptance block
// Assumes: nia_cfg.svh holds the numbers
// Notes:   every instruction kind other than plain defers acceptance
`include "nia_cfg.svh"

package nia_pkg;

    // ============================================================
    // Instruction kinds reported by the core at each completion
    typedef enum logic [2:0] {
        NIA_I_PLAIN,
        NIA_I_ALLOW,
        NIA_I_MASKOFF,
        NIA_I_RET_SVC,
        NIA_I_RET_BRK,
        NIA_I_PSW_WR,
        NIA_I_PSW_POP,
        NIA_I_SKIP
    } nia_instr_type;

    // Status word fields that steer nesting
    typedef struct packed {
        logic       flag;
        logic [1:0] code;
    } nia_psw_type;

    // One instruction completion from the core
    typedef struct packed {
        logic          done;
        nia_instr_type kind;
        nia_psw_type   wdata;
    } nia_core_type;

    localparam nia_psw_type NIA_PSW_RST = '{flag: `NIA_FLAG_RST, code: `NIA_CODE_IDLE};

    // ============================================================
    // Status word writers, returns, allow, mask-off and skips all defer
    function automatic logic nia_defers(input nia_instr_type k);
        return k != NIA_I_PLAIN;
    endfunction : nia_defers

    // Code loaded on acceptance: level minus one, level 0 stays 0
    function automatic logic [1:0] nia_code_of(input logic [1:0] lvl);
        return (lvl == `NIA_LVL_TOP) ? `NIA_LVL_TOP : lvl - `NIA_LVL_STEP;
    endfunction : nia_code_of

endpackage : nia_pkg

//--- nia_stack.sv
// Purpose: stack of saved status words for nested service
// Assumes: push and pop never in the same cycle
// Notes:   top_q always holds the newest entry, or the reset word
`timescale 1ns/1ps
`include "nia_cfg.svh"

module nia_stack
    import nia_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter int AW    = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Stack operations
    input  wire logic        push,
    input  wire logic        pop,
    input  wire nia_psw_type wdata,
    // Stack view
    output nia_psw_type      top_q,
    output logic             empty,
    output logic             ovf
);

    typedef struct packed {
        nia_psw_type [DEPTH-1:0] mem;
        logic [AW-1:0]           sp;
        nia_psw_type             top;
    } nia_stk_state_type;

    nia_stk_state_type s_q;
    nia_stk_state_type s_d;

    // ============================================================
    // Next state; a full stack drops the push and flags it
    always_comb begin
        s_d = s_q;
        ovf = 1'b0;
        if (push) begin
            if (s_q.sp == AW'(DEPTH)) begin
                ovf = 1'b1;
            end else begin
                s_d.mem[s_q.sp] = wdata;
                s_d.sp          = s_q.sp + AW'(1);
                s_d.top         = wdata;
            end
        end else if (pop && s_q.sp != '0) begin
            s_d.sp  = s_q.sp - AW'(1);
            s_d.top = (s_q.sp > AW'(1)) ? s_q.mem[s_q.sp - AW'(2)] : NIA_PSW_RST;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{mem: '0, sp: '0, top: NIA_PSW_RST};
        end else begin
            s_q <= s_d;
        end
    end

    assign top_q = s_q.top;
    assign empty = (s_q.sp == '0);

endmodule : nia_stack

//--- nia_top.sv
// Purpose: decides acceptance of maskable requests, with nesting
// Assumes: the core reports each completed instruction by one pulse
// Notes:   acceptance happens only at instruction boundaries
//
// How it works
// - Nesting occurs only while the accept flag is one.
// - Every acceptance clears the accept flag.
// - The allow instruction sets the accept flag.
// - With flag set, a strictly higher level request nests.
// - Equal or lower level requests never nest, except level 0 over level 0 (code 00 admits level 0).
// - Refused requests stay pending until a later boundary.
// - Programmed levels decide; fixed order only breaks ties.
// - Level field: 00 highest through 11 lowest.
// - In-service code: 00 level 0/1, 01 level 2, 10 level 3, 11 none.
// - With flag set, level L admitted only if L at most the code.
// - After a deferring instruction, accept only after the next one.
// - Status word writes, returns, allow, mask-off and skips defer.
// - Writes to request, mask or level registers also defer.
// - A request counts only when flagged and not masked.
// - Simultaneous requests: best level, then lowest index.
// - Acceptance loads the code with level minus one, floor 00.
// - Returns restore the saved flag and code from the stack.
`timescale 1ns/1ps
`include "nia_cfg.svh"

module nia_top
    import nia_pkg::*;
#(
    parameter int N_SRC     = 8,
    parameter int STK_DEPTH = 4,
    parameter int IW        = $clog2(N_SRC)
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [`NIA_AW-1:0] paddr,
    input  wire logic [`NIA_DW-1:0] pwdata,
    output logic [`NIA_DW-1:0]     prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Request sources
    input  wire logic [N_SRC-1:0]  req_set,
    // CPU core
    input  wire nia_core_type      core,
    output logic                   ack_valid,
    output logic [IW-1:0]          ack_id,
    output nia_psw_type            program_status_word,
    // Event interrupt
    output logic                   irq
);

    typedef struct packed {
        nia_psw_type                 program_status_word;
        logic [N_SRC-1:0]            pend;
        logic [N_SRC-1:0]            mask;
        logic [N_SRC-1:0][1:0]       lvl;
        logic                        ack;
        logic [IW-1:0]               id;
        logic [`NIA_EV_W-1:0]        sts;
        logic [`NIA_EV_W-1:0]        en;
        logic                        irq;
        logic [`NIA_DW-1:0]          rdata;
        logic                        rdy;
        logic                        err;
    } nia_state_type;

    nia_state_type        s_q;
    nia_state_type        s_d;
    logic                 apb_acc;
    logic                 wr;
    logic                 ctl_wr;
    logic [N_SRC-1:0]     cand;
    logic                 found;
    logic [1:0]           best;
    logic [IW-1:0]        best_id;
    logic                 boundary;
    logic                 go;
    logic                 pop;
    logic [`NIA_EV_W-1:0] ev;
    logic [`NIA_EV_W-1:0] clr_w;
    nia_psw_type          stk_top;
    logic                 stk_empty;
    logic                 stk_ovf;

    // ============================================================
    // Saved status words for nested service
    nia_stack #(
        .DEPTH (STK_DEPTH)
    ) u_stack (
        .clk   (pclk),
        .rst_n (presetn),
        .push  (go),
        .pop   (pop),
        .wdata (s_q.program_status_word),
        .top_q (stk_top),
        .empty (stk_empty),
        .ovf   (stk_ovf)
    );

    // ============================================================
    // Bus decode; a second access cycle is ignored while pready stands
    assign apb_acc = psel & penable & ~s_q.rdy;
    assign wr      = apb_acc & pwrite;
    assign ctl_wr  = wr & ((paddr == `NIA_OFF_PEND) | (paddr == `NIA_OFF_MASK) |
                           (paddr == `NIA_OFF_LVL));
    assign clr_w   = (wr && paddr == `NIA_OFF_CLR) ? pwdata[`NIA_EV_W-1:0] : '0;

    // ============================================================
    // Candidate search: unmasked flagged requests only
    assign cand = s_q.pend & ~s_q.mask;

    // Walk down so a lower index wins equal levels
    always_comb begin
        found   = 1'b0;
        best    = `NIA_CODE_IDLE;
        best_id = '0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (cand[i] && (!found || s_q.lvl[i] <= best)) begin
                found   = 1'b1;
                best    = s_q.lvl[i];
                best_id = IW'(i);
            end
        end
    end

    // ============================================================
    // Acceptance only at a boundary that is not deferred
    assign boundary = core.done & ~nia_defers(core.kind) & ~ctl_wr;
    // Level must not exceed the in-service code; code 11 admits all
    assign go = boundary & found & s_q.program_status_word.flag & (best <= s_q.program_status_word.code);
    assign pop = core.done & ~stk_empty &
                 (core.kind == NIA_I_RET_SVC || core.kind == NIA_I_RET_BRK);

    // Events: acceptance, acceptance over service, lost stack word
    always_comb begin
        ev                = '0;
        ev[`NIA_EV_ACC]   = go;
        ev[`NIA_EV_NEST]  = go & (s_q.program_status_word.code != `NIA_CODE_IDLE);
        ev[`NIA_EV_OVF]   = stk_ovf;
    end

    // ============================================================
    // Next state
    always_comb begin
        s_d       = s_q;
        s_d.ack   = 1'b0;
        s_d.rdy   = 1'b0;
        s_d.err   = 1'b0;
        // Register access, answered one cycle into the access phase
        if (apb_acc) begin
            s_d.rdy   = 1'b1;
            s_d.rdata = '0;
            case (paddr)
                `NIA_OFF_PSW: begin
                    s_d.rdata[`NIA_PSW_FLAG_BIT]                       = s_q.program_status_word.flag;
                    s_d.rdata[`NIA_PSW_CODE_LSB +: 2]                  = s_q.program_status_word.code;
                end
                `NIA_OFF_PEND: begin
                    s_d.rdata[N_SRC-1:0] = s_q.pend;
                    if (pwrite) begin
                        s_d.pend = pwdata[N_SRC-1:0];
                    end
                end
                `NIA_OFF_MASK: begin
                    s_d.rdata[N_SRC-1:0] = s_q.mask;
                    if (pwrite) begin
                        s_d.mask = pwdata[N_SRC-1:0];
                    end
                end
                `NIA_OFF_LVL: begin
                    s_d.rdata[2*N_SRC-1:0] = s_q.lvl;
                    if (pwrite) begin
                        s_d.lvl = pwdata[2*N_SRC-1:0];
                    end
                end
                `NIA_OFF_STS: begin
                    s_d.rdata[`NIA_EV_W-1:0] = s_q.sts;
                end
                `NIA_OFF_CLR: begin
                    s_d.rdata = '0;
                end
                `NIA_OFF_EN: begin
                    s_d.rdata[`NIA_EV_W-1:0] = s_q.en;
                    if (pwrite) begin
                        s_d.en = pwdata[`NIA_EV_W-1:0];
                    end
                end
                default: begin
                    s_d.err = 1'b1;
                end
            endcase
        end
        // Status word effects of the completed instruction
        if (core.done) begin
            case (core.kind)
                NIA_I_ALLOW: begin
                    s_d.program_status_word.flag = 1'b1;
                end
                NIA_I_MASKOFF: begin
                    s_d.program_status_word.flag = 1'b0;
                end
                NIA_I_RET_SVC, NIA_I_RET_BRK: begin
                    if (!stk_empty) begin
                        s_d.program_status_word = stk_top;
                    end
                end
                NIA_I_PSW_WR, NIA_I_PSW_POP: begin
                    s_d.program_status_word = core.wdata;
                end
                default: begin
                    s_d.program_status_word = s_q.program_status_word;
                end
            endcase
        end
        // Acceptance; never coincides with a status word change above
        if (go) begin
            s_d.program_status_word.flag          = 1'b0;
            s_d.program_status_word.code          = nia_code_of(best);
            s_d.pend[best_id]     = 1'b0;
            s_d.ack               = 1'b1;
            s_d.id                = best_id;
        end
        // Refused requests stay flagged; a new request beats the clear
        s_d.pend = s_d.pend | req_set;
        // Sticky events, set wins over clear
        s_d.sts = (s_q.sts & ~clr_w) | ev;
        s_d.irq = |(s_d.sts & s_d.en);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q      <= '0;
            s_q.program_status_word  <= NIA_PSW_RST;
            s_q.mask <= '1;
            s_q.lvl  <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    // ============================================================
    // Outputs, all from the state register
    assign prdata    = s_q.rdata;
    assign pready    = s_q.rdy;
    assign pslverr   = s_q.err;
    assign ack_valid = s_q.ack;
    assign ack_id    = s_q.id;
    assign program_status_word       = s_q.program_status_word;
    assign irq       = s_q.irq;

    // ============================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Acceptance gating by the accept flag
    AST_FLAG_CLEARED: assert property (s_q.ack |-> !s_q.program_status_word.flag)
        else $error("accept flag still set after acceptance");
    AST_NO_ACK_FLAG_OFF: assert property ((core.done && !s_q.program_status_word.flag) |=> !s_q.ack)
        else $error("acceptance while accept flag clear");
    AST_ALLOW_SETS: assert property ((core.done && core.kind == NIA_I_ALLOW)
        |=> s_q.program_status_word.flag && !s_q.ack)
        else $error("allow instruction did not set the flag");
    // Deferrals and refusals; a refused request must still be pending
    AST_DEFER_HOLDS: assert property ((core.done && core.kind != NIA_I_PLAIN)
        |=> !s_q.ack)
        else $error("acceptance at a deferring instruction");
    AST_LOW_REFUSED: assert property ((boundary && found && best > s_q.program_status_word.code)
        |=> !s_q.ack && s_q.pend[$past(best_id)])
        else $error("lower level request nested");
    // Code after acceptance: level minus one, level 0 stays at the top code
    AST_CODE_LOAD: assert property (go |=> s_q.ack && s_q.id == $past(best_id)
        && s_q.program_status_word.code == (($past(best) == `NIA_LVL_TOP) ? `NIA_LVL_TOP
                            : $past(best) - `NIA_LVL_STEP))
        else $error("wrong in-service code after acceptance");
    AST_MASKED_IGNORED: assert property ((core.done && cand == '0) |=> !s_q.ack)
        else $error("acceptance with no unmasked request");
    AST_RET_RESTORE: assert property (pop |=> s_q.program_status_word == $past(stk_top))
        else $error("return did not restore the saved word");
    AST_CTL_WR_DEFERS: assert property ((core.done && ctl_wr) |=> !s_q.ack)
        else $error("acceptance in a control register write cycle");
    AST_PENDING_KEPT: assert property ((s_q.pend[0] && !s_q.ack && !ctl_wr)
        |=> s_q.pend[0] || (s_q.ack && s_q.id == '0))
        else $error("pending request lost");
    // Events reach the sticky status at the edge that follows their cause
    AST_NEST_EVENT: assert property ((go && s_q.program_status_word.code != `NIA_CODE_IDLE)
        |=> s_q.sts[`NIA_EV_NEST])
        else $error("nested acceptance not recorded");
    AST_OVF_FLAGGED: assert property (stk_ovf |=> s_q.sts[`NIA_EV_OVF])
        else $error("dropped stack word not recorded");

    // Main scenarios
    COV_NESTED: cover property (go && s_q.program_status_word.code != `NIA_CODE_IDLE);
    COV_REFUSED: cover property (boundary && found && s_q.program_status_word.flag && best > s_q.program_status_word.code);
    COV_RETURN: cover property (pop ##1 go);
    COV_CTL_BLOCK: cover property (core.done && ctl_wr && found && s_q.program_status_word.flag);
    COV_OVERFLOW: cover property (stk_ovf);

endmodule : nia_top

//--- nia_core_model.sv
// Purpose: stand-in for the CPU core that reports completed instructions
// Assumes: the bench raises cmd_valid for one cycle per instruction
// Notes:   outside a completion the kind and word lines toggle every cycle
`timescale 1ns/1ps

module nia_core_model
    import nia_pkg::*;
(
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // Bench commands
    input  wire logic          cmd_valid,
    input  wire nia_instr_type cmd_kind,
    input  wire nia_psw_type   cmd_wdata,
    // Completion towards the block
    output nia_core_type       core
);
    logic [5:0] junk_q;

    // ============================================================
    // Idle filler flips each cycle, so stale fields never look valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            junk_q <= 6'h2a;
        end else begin
            junk_q <= ~junk_q;
        end
    end

    // Every kind, deferring or not, reaches the block as issued
    assign core = cmd_valid ? {1'b1, cmd_kind, cmd_wdata} : {1'b0, junk_q};
endmodule : nia_core_model

//--- tb_nia_top.sv
// Purpose: self-checking bench for the nested acceptance block
// Assumes: completions come from nia_core_model, request pulses from here
// Notes:   expectations follow the level and in-service code tables
`timescale 1ns/1ps
`include "nia_cfg.svh"

module tb_nia_top
    import nia_pkg::*;
;
    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0000_0000;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic [7:0]    req_set = 8'h00;
    logic          cmd_valid = 1'b0;
    nia_instr_type cmd_kind = NIA_I_PLAIN;
    nia_psw_type   cmd_wdata = 3'h7;
    nia_core_type  core;
    logic          ack_valid;
    logic [2:0]    ack_id;
    nia_psw_type   program_status_word;
    logic          irq;
    logic          last_err;
    logic [31:0]   q;
    int            error_cnt = 0;
    int            checks_done = 0;
    int            cyc = 0;

    nia_top i_nia_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req_set(req_set), .core(core), .ack_valid(ack_valid),
        .ack_id(ack_id), .program_status_word(program_status_word), .irq(irq));

    nia_core_model i_nia_core_model (.pclk(pclk), .presetn(presetn), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_wdata(cmd_wdata), .core(core));

    // ============================================================
    // Clock and hang guard, a few hundred cycles of work expected
    always #5 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            finish_test();
        end
    end

    // ============================================================
    // Shared helpers
    task automatic finish_test();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask : chk

    // APB transfer; request held until pready is sampled high, a hang ends in the timeout
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp, "register read");
    endtask : rdc

    // One completed instruction; acceptance shows one edge after done
    task automatic ins(input nia_instr_type k, input nia_psw_type w, input logic exp);
        @(posedge pclk);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        cmd_wdata <= w;
        @(posedge pclk);
        cmd_valid <= 1'b0;
        #1;
        chk(ack_valid, exp, "acceptance");
    endtask : ins

    task automatic rq(input logic [7:0] m);
        @(posedge pclk);
        req_set <= m;
        @(posedge pclk);
        req_set <= 8'h00;
    endtask : rq

    task automatic settle();
        @(posedge pclk);
        #1;
    endtask : settle

    // ============================================================
    // Scenarios
    task automatic t_reset();
        chk(program_status_word, 3'h3, "reset status word");
        rdc(`NIA_OFF_PSW, 32'h0000_0006);
        rdc(`NIA_OFF_MASK, 32'h0000_00ff);
        rdc(`NIA_OFF_LVL, 32'h0000_ffff);
        rdc(`NIA_OFF_PEND, 32'h0000_0000);
        rdc(8'h1c, 32'h0000_0000);
        chk(last_err, 1'b1, "unmapped error");
        apb(1'b1, `NIA_OFF_PSW, 32'h0000_00ff);
        rdc(`NIA_OFF_PSW, 32'h0000_0006);
    endtask : t_reset

    // Levels: src2,4 at 0, src6 at 1, src3,5 at 2, src0,1,7 at 3
    task automatic t_basic();
        apb(1'b1, `NIA_OFF_LVL, 32'h0000_d88f);
        rdc(`NIA_OFF_LVL, 32'h0000_d88f);
        rq(8'h08);
        apb(1'b1, `NIA_OFF_MASK, 32'h0000_00f7);
        ins(NIA_I_PLAIN, 3'h7, 1'b0);
        ins(NIA_I_ALLOW, 3'h7, 1'b0);
        chk(program_status_word, 3'h7, "flag set");
        apb(1'b1, `NIA_OFF_MASK, 32'h0000_00ff);
        ins(NIA_I_PLAIN, 3'h7, 1'b0);
        rdc(`NIA_OFF_PEND, 32'h0000_0008);
        apb(1'b1, `NIA_OFF_MASK, 32'h0000_00f7);
        ins(NIA_I_PLAIN, 3'h7, 1'b1);
        chk(ack_id, 3'h3, "accepted source");
        chk(program_status_word, 3'h1, "flag cleared, code of level 2");
        rdc(`NIA_OFF_PEND, 32'h0000_0000);
    endtask : t_basic

    task automatic t_nest();
        apb(1'b1, `NIA_OFF_MASK, 32'h0000_0000);
        ins(NIA_I_ALLOW, 3'h7, 1'b0);
        rq(8'h22);
        ins(NIA_I_PLAIN, 3'h7, 1'b0);
        rq(8'h40);
        ins(NIA_I_PLAIN, 3'h7, 1'b1);
        chk(ack_id, 3'h6, "nested source");
        chk(program_status_word, 3'h0, "code of level 1");
        rdc(`NIA_OFF_STS, 32'h0000_0003);
        ins(NIA_I_RET_SVC, 3'h7, 1'b0);
        chk(program_status_word, 3'h5, "restored word");
        ins(NIA_I_PLAIN, 3'h7, 1'b0);
        ins(NIA_I_RET_SVC, 3'h7, 1'b0);
        chk(program_status_word, 3'h7, "restored idle word");
        ins(NIA_I_PLAIN, 3'h7, 1'b1);
        chk(ack_id, 3'h5, "level beats index");
        ins(NIA_I_ALLOW, 3'h7, 1'b0);
        ins(NIA_I_PLAIN, 3'h7, 1'b0);
    endtask : t_nest

    // Every deferring kind, then a plain boundary with a level 0 tie
    task automatic t_defer();
        nia_instr_type ks[7];
        logic          e;
        ks = '{NIA_I_ALLOW, NIA_I_MASKOFF, NIA_I_RET_SVC, NIA_I_RET_BRK,
               NIA_I_PSW_WR, NIA_I_PSW_POP, NIA_I_SKIP};
        foreach (ks[i]) begin
            e = (ks[i] != NIA_I_MASKOFF);
            ins(NIA_I_PSW_WR, 3'h7, 1'b0);
            rq(8'h14);
            ins(ks[i], 3'h7, 1'b0);
            ins(NIA_I_PLAIN, 3'h7, e);
            if (e) begin
                chk(ack_id, 3'h2, "tie to lowest index");
                chk(program_status_word, 3'h0, "code of level 0");
            end
        end
        ins(NIA_I_PSW_WR, 3'h7, 1'b0);
        rq(8'h04);
        fork
            apb(1'b1, `NIA_OFF_MASK, 32'h0000_0000);
            begin
                @(posedge pclk);
                ins(NIA_I_PLAIN, 3'h7, 1'b0);
            end
        join
        ins(NIA_I_PLAIN, 3'h7, 1'b1);
        rdc(`NIA_OFF_STS, 32'h0000_0007);
    endtask : t_defer

    task automatic t_irq();
        apb(1'b1, `NIA_OFF_CLR, 32'h0000_0007);
        rdc(`NIA_OFF_STS, 32'h0000_0000);
        apb(1'b1, `NIA_OFF_EN, 32'h0000_0001);
        settle();
        chk(irq, 1'b0, "irq idle");
        rq(8'h04);
        ins(NIA_I_PSW_WR, 3'h7, 1'b0);
        ins(NIA_I_PLAIN, 3'h7, 1'b1);
        settle();
        chk(irq, 1'b1, "irq on acceptance");
        apb(1'b0, `NIA_OFF_STS, 32'h0000_0000);
        chk(q[0], 1'b1, "sticky accept bit");
        apb(1'b1, `NIA_OFF_EN, 32'h0000_0000);
        settle();
        chk(irq, 1'b0, "irq masked");
        apb(1'b1, `NIA_OFF_EN, 32'h0000_0001);
        settle();
        chk(irq, 1'b1, "irq unmasked");
        apb(1'b1, `NIA_OFF_CLR, 32'h0000_0007);
        settle();
        chk(irq, 1'b0, "irq cleared");
        rdc(`NIA_OFF_CLR, 32'h0000_0000);
    endtask : t_irq

    // ============================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        t_reset();
        t_basic();
        t_nest();
        t_defer();
        t_irq();
        finish_test();
    end
endmodule : tb_nia_top
